// [dv/dai_indicator_sva.sv]
`timescale 1ns/1ps
// Port-level checks of the indicator block
module dai_indicator_sva
	import dai_pkg::*;
#(
	parameter int BLINK_HALF_CYCLES = 4
)
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB handshake
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	// Drive state and pin
	input wire dai_spindle_e spindle_state,
	input wire logic command_active,
	input wire logic format_active,
	input wire logic cylinder_change,
	input wire logic drive_indicator_out,
	input wire logic drive_indicator_out_oe
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Shorthands
	wire logic oe = drive_indicator_out_oe;
	wire logic mv = spindle_state == DAI_SPIN_MOVING;
	wire logic up = spindle_state == DAI_SPIN_UP;
	wire logic dn = spindle_state == DAI_SPIN_DOWN;
	wire logic fm = format_active;
	// Lit half, then dark half, of one blink
	sequence s_lit_half;
		##BLINK_HALF_CYCLES oe;
	endsequence
	sequence s_dark_half;
		##1 !oe ##BLINK_HALF_CYCLES oe;
	endsequence
	down_idle_a: assert property (dn && !command_active && !fm |=> !oe)
		else $error("lamp lit while spun down and idle");
	down_busy_a: assert property (dn && command_active && !fm |=> oe)
		else $error("lamp dark while spun down and busy");
	up_flip_a: assert property (up && $past(up) && !fm && !$past(fm)
		&& $changed(command_active) |=> $changed(oe))
		else $error("activity change did not flip lamp");
	blink_run_a: assert property ($rose(mv) |-> s_lit_half ##0 s_dark_half)
		else $error("blink timing wrong");
	fmt_flip_a: assert property (fm && $past(fm) && !mv && cylinder_change
		|=> oe != $past(oe))
		else $error("cylinder change did not toggle lamp");
	fmt_hold_a: assert property (fm && $past(fm) && !mv && !cylinder_change
		|=> $stable(oe))
		else $error("lamp moved during format without cylinder change");
	pin_low_a: assert property (!drive_indicator_out)
		else $error("pin driven high");
	apb_answer_a: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("APB answer not one cycle after setup");
endmodule : dai_indicator_sva

bind dai_indicator dai_indicator_sva #(
	.BLINK_HALF_CYCLES(BLINK_HALF_CYCLES)
) i_sva (.pclk, .presetn, .psel, .penable, .pready, .spindle_state,
	.command_active, .format_active, .cylinder_change,
	.drive_indicator_out, .drive_indicator_out_oe);

// [dv/dai_indicator_tb_top.sv]
`timescale 1ns/1ps
// Self-checking bench of the drive indicator
module dai_indicator_tb_top
	import dai_pkg::*;
;
	localparam int H = 4; // Short blink keeps the run brief
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
	logic pwrite = 1'h0, pready, pslverr, e, lamp_lit;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic [3:0] pstrb = 4'hF;
	logic cylinder_change = 1'h0, command_active = 1'h0, format_active = 1'h0;
	logic remote_power_off = 1'h1;
	logic drive_indicator_out, drive_indicator_out_oe;
	dai_spindle_e spindle_state = DAI_SPIN_DOWN;
	int miscompares = 0, check_count = 0;
	always #25 pclk = ~pclk;
	dai_indicator #(.BLINK_HALF_CYCLES(H)) i_dut (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
		.spindle_state, .command_active, .format_active, .cylinder_change,
		.remote_power_off, .drive_indicator_out, .drive_indicator_out_oe);
	dai_led_model i_led (.drive_indicator_out, .drive_indicator_out_oe,
		.lamp_lit);
	// Compare and count
	task automatic chk(input string nm, input logic [31:0] got, exp);
		check_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH %s exp %0h got %0h", nm, exp, got);
		end
	endtask : chk
	// One APB transfer; holds the request until pready is seen at an edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] rd, output logic er);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
		@(posedge pclk);
		penable <= 1'h1;
		// Only the watchdog ends a wait that never completes
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'h0;
	endtask : apb
	// Drive state change at a rising edge
	task automatic drv(input dai_spindle_e sp, input logic c);
		@(posedge pclk);
		spindle_state <= sp;
		command_active <= c;
	endtask : drv
	// Lamp after inputs have settled through the pipeline
	task automatic lamp(input logic exp);
		repeat (2) @(posedge pclk);
		@(negedge pclk);
		chk("lamp", lamp_lit, exp);
	endtask : lamp
	task automatic test_done;
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done
	// Hang guard
	initial
	begin
		repeat (2000) @(posedge pclk);
		miscompares++;
		test_done();
	end
	// Test sequence
	initial
	begin
		repeat (8) @(posedge pclk);
		presetn <= 1'h1;
		apb(1'h0, 12'h000, 32'h0, r, e);
		chk("ctrl_reset", r, 32'h0);
		// Spun-down and spun-up rows of the activity table for both polarities
		for (int p = 0; p < 2; p++)
		begin
			apb(1'h1, 12'h000, p, r, e);
			for (int s = 0; s < 2; s++)
				for (int c = 0; c < 2; c++)
				begin
					drv(s ? DAI_SPIN_UP : DAI_SPIN_DOWN, c[0]);
					lamp(s ? c[0] ^ ~p[0] : c[0]);
				end
		end
		// Write with bit 0 strobe off leaves polarity alone
		pstrb <= 4'hE;
		apb(1'h1, 12'h000, 32'h0, r, e);
		pstrb <= 4'hF;
		apb(1'h0, 12'h000, 32'h0, r, e);
		chk("ctrl_masked", r, 32'h1);
		// Status is read-only; a write is ignored without error
		apb(1'h1, 12'h004, 32'h0, r, e);
		chk("stat_wr_err", e, 1'h0);
		apb(1'h0, 12'h004, 32'h0, r, e);
		chk("stat_pwroff", r[5], 1'h1);
		chk("stat_lit", r[0], 1'h1);
		chk("stat_spin", r[2:1], 32'h1);
		apb(1'h0, 12'h008, 32'h0, r, e);
		chk("unmapped_err", e, 1'h1);
		// Spin change: lit half first, dark half next
		drv(DAI_SPIN_MOVING, 1'h0);
		lamp(1'h1);
		repeat (H) @(posedge pclk);
		@(negedge pclk);
		chk("blink_dark", lamp_lit, 1'h0);
		repeat (2 * H) @(posedge pclk);
		drv(DAI_SPIN_UP, 1'h0);
		lamp(1'h0);
		// Format ignores activity, toggles on cylinder change
		@(posedge pclk);
		format_active <= 1'h1;
		command_active <= 1'h1;
		lamp(1'h0);
		@(posedge pclk);
		cylinder_change <= 1'h1;
		@(posedge pclk);
		cylinder_change <= 1'h0;
		lamp(1'h1);
		test_done();
	end
endmodule : dai_indicator_tb_top

// [dv/dai_led_model.sv]
`timescale 1ns/1ps
// Backplane LED with resistor to the supply; the resistor pulls the line up
module dai_led_model
(
	// Pin from the drive
	input wire logic drive_indicator_out,
	input wire logic drive_indicator_out_oe,
	// Lamp seen by the operator
	output logic lamp_lit
);
	// Released line floats up, so only a driven low lights the lamp
	wire logic pin = drive_indicator_out_oe ? drive_indicator_out : 1'h1;
	assign lamp_lit = pin === 1'h0;
endmodule : dai_led_model

// [logic/dai_blink_timer.sv]
`timescale 1ns/1ps
`include "dai_regs.svh"

// Free-running half-period timer that yields a square wave while run is high
module dai_blink_timer
	import dai_pkg::*;
#(
	parameter int unsigned HALF_CYCLES = 10000000
)
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control and result
	input wire logic run,
	output logic phase
);

	// Counter width sized to the half period
	localparam int unsigned CW = $clog2(HALF_CYCLES + 1);

	// A zero half period cannot produce a blink
	generate
		if (HALF_CYCLES < 1)
		begin : g_bad_half
			$error("dai_blink_timer: HALF_CYCLES must be at least 1");
		end
	endgenerate

	dai_blink_s st;
	dai_blink_s next_st;

	// Count half periods and flip the phase at each wrap
	always_comb
	begin
		next_st = st;
		if (!run)
		begin
			// Idle: rearm so every blink run opens with a full lit half
			next_st.count = '0;
			next_st.phase = 1'b1;
		end
		else if (st.count[CW-1:0] == CW'(HALF_CYCLES - 1))
		begin
			// End of a half period
			next_st.count = '0;
			next_st.phase = ~st.phase;
		end
		else
		begin
			next_st.count = st.count + 32'h0000_0001;
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st <= '{count: 32'h0000_0000, phase: 1'b1};
		end
		else
		begin
			st <= next_st;
		end
	end

	assign phase = st.phase;

endmodule : dai_blink_timer

// [logic/dai_indicator.sv]
`timescale 1ns/1ps
`include "dai_regs.svh"


module dai_indicator
	import dai_pkg::*;
#(
	// Half blink period in clock cycles; shorten it for simulation
	parameter int unsigned BLINK_HALF_CYCLES =
		`DAI_BLINK_HALF_MS * (`DAI_PCLK_HZ / `DAI_MS_PER_S)
)
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`DAI_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Drive state
	input wire dai_spindle_e spindle_state,
	input wire logic command_active,
	input wire logic format_active,
	input wire logic cylinder_change,
	input wire logic remote_power_off,
	// Open-collector indicator pin
	output logic drive_indicator_out,
	output logic drive_indicator_out_oe
);

	// The blink must last at least one cycle
	generate
		if (BLINK_HALF_CYCLES < 1)
		begin : g_bad_blink
			$error("dai_indicator: BLINK_HALF_CYCLES must be at least 1");
		end
	endgenerate

	dai_state_s st; // Registered state
	dai_state_s next_st; // Next state
	logic blink_phase; // Square wave from the timer
	logic spin_moving; // Spindle is accelerating or decelerating
	logic act_lit; // Lit level from the activity table
	logic want_lit; // Lit level after all overrides
	logic setup; // APB setup phase
	logic access; // APB access phase that completes this edge
	logic hit_ctrl; // Address decodes to the control register
	logic hit_stat; // Address decodes to the status register
	logic [31:0] stat_word; // Live status value

	// Control reset word; only the polarity bit is kept in the state
	localparam logic [31:0] CTRL_RESET_WORD = `DAI_CTRL_RESET;

	// Timer runs only during a spin transition so each run starts lit
	assign spin_moving = (spindle_state == DAI_SPIN_MOVING);

	dai_blink_timer #(
		.HALF_CYCLES(BLINK_HALF_CYCLES)
	) u_blink (
		.pclk(pclk),
		.presetn(presetn),
		.run(spin_moving),
		.phase(blink_phase)
	);

	// Activity table lookup
	always_comb
	begin
		case (spindle_state)
			DAI_SPIN_DOWN:
			begin
				// Polarity plays no part while spun down
				act_lit = command_active;
			end
			DAI_SPIN_UP:
			begin
				// Idle lit for polarity 0, busy lit for polarity 1
				act_lit = st.polarity ? command_active
					: ~command_active;
			end
			default:
			begin
				// Undefined spindle code: keep the lamp dark
				act_lit = 1'b0;
			end
		endcase
	end

	// APB decode
	assign setup = psel && !penable;
	assign access = psel && penable && st.pready;
	assign hit_ctrl = (paddr == `DAI_CTRL_OFFSET);
	assign hit_stat = (paddr == `DAI_STATUS_OFFSET);

	// Status word assembled from live inputs and current drive of the pin
	always_comb
	begin
		stat_word = 32'h0000_0000;
		stat_word[`DAI_STAT_LIT_BIT] = st.led_oe;
		stat_word[`DAI_STAT_SPIN_HI:`DAI_STAT_SPIN_LO] = spindle_state;
		stat_word[`DAI_STAT_BUSY_BIT] = command_active;
		stat_word[`DAI_STAT_FMT_BIT] = format_active;
		stat_word[`DAI_STAT_PWROFF_BIT] = remote_power_off;
		stat_word[`DAI_STAT_BLINK_BIT] = (st.src == DAI_SRC_BLINK);
	end

	// Next state: source selection, format toggle, pin drive and bus
	always_comb
	begin
		next_st = st;
		want_lit = act_lit;

		// Pick the owner of the lamp; blink beats format beats activity
		if (spin_moving)
		begin
			next_st.src = DAI_SRC_BLINK;
			want_lit = blink_phase;
		end
		else if (format_active)
		begin
			next_st.src = DAI_SRC_FORMAT;
			if (st.src != DAI_SRC_FORMAT)
			begin
				// Entry: carry on from the lamp as it stands now
				next_st.fmt_lit = st.led_oe ^ cylinder_change;
			end
			else if (cylinder_change)
			begin
				next_st.fmt_lit = ~st.fmt_lit;
			end
			want_lit = next_st.fmt_lit;
		end
		else
		begin
			next_st.src = DAI_SRC_ACTIVITY;
		end

		// Lit pulls the pin low; unlit releases it to the pull-up
		next_st.led_out = 1'b0;
		next_st.led_oe = want_lit;

		// Bus: one wait-free access phase, ready raised from setup
		next_st.pready = setup;
		next_st.pslverr = 1'b0;
		next_st.prdata = 32'h0000_0000;
		if (setup)
		begin
			// Unmapped addresses answer with an error and zero data
			next_st.pslverr = !(hit_ctrl || hit_stat);
			if (!pwrite && hit_ctrl)
			begin
				next_st.prdata[`DAI_CTRL_POL_BIT] = st.polarity;
			end
			else if (!pwrite && hit_stat)
			begin
				next_st.prdata = stat_word;
			end
		end
		else if (access)
		begin
			// Drop the answer at the completing edge
			next_st.pready = 1'b0;
			next_st.pslverr = 1'b0;
			next_st.prdata = 32'h0000_0000;
		end

		// Control write takes effect at the completing edge only
		if (access && pwrite && hit_ctrl && pstrb[0])
		begin
			next_st.polarity = pwdata[`DAI_CTRL_POL_BIT];
		end
	end

	// State register; reset leaves the pin released and the bus idle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st <= '{polarity: CTRL_RESET_WORD[`DAI_CTRL_POL_BIT],
				src: DAI_SRC_ACTIVITY,
				fmt_lit: 1'b0,
				led_oe: 1'b0,
				led_out: 1'b0,
				pready: 1'b0,
				pslverr: 1'b0,
				prdata: 32'h0000_0000};
		end
		else
		begin
			st <= next_st;
		end
	end

	// Outputs straight from the state register
	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign drive_indicator_out = st.led_out;
	assign drive_indicator_out_oe = st.led_oe;

endmodule : dai_indicator

// [logic/dai_pkg.sv]
package dai_pkg;

	// Spindle condition reported by the drive's motor control
	typedef enum logic [1:0] {
		DAI_SPIN_DOWN,
		DAI_SPIN_UP,
		DAI_SPIN_MOVING
	} dai_spindle_e;

	// Which behaviour currently owns the indicator
	typedef enum logic [1:0] {
		DAI_SRC_ACTIVITY,
		DAI_SRC_BLINK,
		DAI_SRC_FORMAT
	} dai_src_e;

	// Whole state of the indicator block
	typedef struct packed {
		logic polarity;
		dai_src_e src;
		logic fmt_lit;
		logic led_oe;
		logic led_out;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} dai_state_s;

	// Whole state of the blink timer
	typedef struct packed {
		logic [31:0] count;
		logic phase;
	} dai_blink_s;

endpackage : dai_pkg

// [logic/dai_regs.svh]
`ifndef DAI_REGS_SVH
`define DAI_REGS_SVH

// Register byte offsets on the APB window
`define DAI_CTRL_OFFSET 12'h000
`define DAI_STATUS_OFFSET 12'h004

// Width of the decoded part of paddr
`define DAI_ADDR_W 12

// Control register fields and reset values
`define DAI_CTRL_POL_BIT 0
`define DAI_CTRL_RESET 32'h0000_0000

// Status register field positions
`define DAI_STAT_LIT_BIT 0
`define DAI_STAT_SPIN_LO 1
`define DAI_STAT_SPIN_HI 2
`define DAI_STAT_BUSY_BIT 3
`define DAI_STAT_FMT_BIT 4
`define DAI_STAT_PWROFF_BIT 5
`define DAI_STAT_BLINK_BIT 6

// Blink timing: half period in milliseconds, clock in hertz
`define DAI_BLINK_HALF_MS 500
`define DAI_PCLK_HZ 20000000
`define DAI_MS_PER_S 1000

`endif
